// ==== serial_master_port.sv ====
`timescale 1ns/1ps
// master-only synchronous serial port with programmable length, clocking and select delays

// Functional notes
// [RQ1] The port is master only and always generates the serial clock itself.
// [RQ2] Two active-low select outputs address one of two slaves on shared lines.
// [RQ3] Three-line mode leaves both selects high; four-line mode drives the chosen select.
// [RQ4] Characters of 2 to 16 bits shift through a 16-bit shift register.
// [RQ5] One interrupt output plus separate receive and transmit DMA events.
// [RQ6] The serial clock period is the module clock period times an 8-bit prescaler divider; odd values above 1 give one clock less, 0 and 1 give two.
// [RQ7] Clock polarity and phase (no delay or delay) are programmable.
// [RQ8] With phase 0, data out changes on rising edge for polarity 0 and falling for polarity 1.
// [RQ9] With phase 0, data in is captured on falling edge for polarity 0 and rising for polarity 1.
// [RQ10] At least two module clocks plus a programmable delay pass from select low to first clock edge.
// [RQ11] Select stays low one module clock plus half a serial period plus a programmable delay after the last edge.
// [RQ12] No general-purpose pin control is offered by this port.
// [RQ13] A finished character moves to a readable receive buffer, then raises receive event.
module serial_master_port (
  // clock and reset
  input  wire logic          CORE_CLK,
  input  wire logic          NRST,
  // configuration
  input  wire smp_pkg::cfg_s CFG,
  // transmit request
  input  wire logic          TX_VALID,
  output logic               TX_READY,
  input  wire logic [15:0]   TX_DATA,
  // receive buffer
  output logic               RX_VALID,
  input  wire logic          RX_READY,
  output logic [15:0]        RX_DATA,
  // events
  output logic               IRQ,
  output logic               RX_DMA_REQ,
  output logic               TX_DMA_REQ,
  output logic               BUSY,
  // serial pins
  output logic               SCLK,
  output logic               SDO,
  input  wire logic          SERIAL_DATA_IN,
  output logic [1:0]         SEL_N
);
  smp_pkg::state_e state_r, state_nxt;
  smp_pkg::cfg_s   cfg_r;
  logic [15:0] tx_sh_r;
  logic [15:0] rx_sh_r;
  logic [4:0]  bits_r;
  logic [7:0]  div_r;
  logic [8:0]  wait_r;
  logic [4:0]  len_eff_r;
  logic        sclk_r;
  logic        sdo_r;
  logic [1:0]  sel_n_r;
  logic        din_m_r, din_s_r;
  logic        done_r;
  logic        txreq_r;
  logic        rx_push;
  logic        rx_ready_in;

  // pin input synchroniser
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      din_m_r <= 1'b0;
      din_s_r <= 1'b0;
    end else begin
      din_m_r <= SERIAL_DATA_IN;
      din_s_r <= din_m_r;
    end
  end

  // prescaler tick and half-period phase decoding
  wire [7:0] half_top   = (cfg_r.prescale < 8'h02) ? smp_pkg::ONE8 : (cfg_r.prescale >> 1);
  wire       half_tick  = (div_r == smp_pkg::ONE8); // RQ6
  wire       start_ok   = TX_VALID && (state_r == smp_pkg::ST_IDLE) && rx_ready_in;
  wire [4:0] len_eff    = (CFG.char_len < smp_pkg::LEN_MIN) ? smp_pkg::LEN_MIN :
                          (CFG.char_len > smp_pkg::LEN_MAX) ? smp_pkg::LEN_MAX : CFG.char_len; // RQ4
  wire [15:0] tx_align  = TX_DATA << (5'h10 - len_eff);
  wire       last_bit   = (bits_r == smp_pkg::ONE5);
  wire       wait_done  = (wait_r == {1'b0, smp_pkg::ONE8});
  // select waits are one bit wider so the largest delay settings cannot wrap to an instant wait
  wire [8:0] setup_load = {1'b0, smp_pkg::SEL_SETUP_MIN} + {1'b0, CFG.select_to_clock_delay}; // RQ10
  wire [8:0] hold_load  = {1'b0, smp_pkg::SEL_HOLD_MIN} + {1'b0, half_top} +
                          {1'b0, cfg_r.clock_to_deselect_delay}; // RQ11
  wire       in_lead    = (state_r == smp_pkg::ST_LEAD);
  wire       in_trail   = (state_r == smp_pkg::ST_TRAIL);

  assign TX_READY = (state_r == smp_pkg::ST_IDLE) && rx_ready_in;
  assign BUSY     = (state_r != smp_pkg::ST_IDLE);

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      smp_pkg::ST_IDLE:  if (start_ok) state_nxt = smp_pkg::ST_SETUP;
      smp_pkg::ST_SETUP: if (wait_done) state_nxt = smp_pkg::ST_LEAD; // RQ10
      smp_pkg::ST_LEAD:  if (half_tick) state_nxt = smp_pkg::ST_TRAIL;
      smp_pkg::ST_TRAIL: if (half_tick) state_nxt = last_bit ? smp_pkg::ST_HOLD : smp_pkg::ST_LEAD;
      smp_pkg::ST_HOLD:  if (wait_done) state_nxt = smp_pkg::ST_IDLE; // RQ11
      default:           state_nxt = smp_pkg::ST_IDLE;
    endcase
  end

  // state and configuration capture
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= smp_pkg::ST_IDLE;
      cfg_r   <= '0;
    end else begin
      state_r <= state_nxt;
      if (start_ok) cfg_r <= CFG;
    end
  end

  // half-period divider: each half serial period is half the prescaler value rounded down, at least one clock
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      div_r <= smp_pkg::ONE8;
    end else if (state_nxt != state_r || half_tick) begin
      div_r <= half_top; // RQ6
    end else if (in_lead || in_trail) begin
      div_r <= div_r - smp_pkg::ONE8;
    end
  end

  // select setup and hold wait counter
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      wait_r <= {1'b0, smp_pkg::ONE8};
    end else if (start_ok) begin
      wait_r <= setup_load; // RQ10
    end else if (in_trail && half_tick && last_bit) begin
      wait_r <= hold_load; // RQ11
    end else if (!wait_done) begin
      wait_r <= wait_r - {1'b0, smp_pkg::ONE8};
    end
  end

  // shift registers and bit counter; phase 0 launches on the leading edge and captures on the trailing,
  // phase 1 presents its first bit at select, captures on the leading edge and launches on the trailing
  wire launch_lead  = in_lead && half_tick && !cfg_r.phase; // RQ8
  wire launch_trail = in_trail && half_tick && cfg_r.phase && !last_bit; // RQ7
  wire capture      = half_tick && (cfg_r.phase ? in_lead : in_trail); // RQ9
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      tx_sh_r <= 16'h0000;
      rx_sh_r <= 16'h0000;
      bits_r  <= 5'h00;
      sdo_r   <= 1'b0;
    end else begin
      if (start_ok) begin
        tx_sh_r <= tx_align << 1; // RQ4
        sdo_r   <= tx_align[15];
        bits_r  <= len_eff;
        rx_sh_r <= 16'h0000;
      end else begin
        if (launch_lead && !(bits_r == len_eff_r)) begin
          sdo_r   <= tx_sh_r[15];
          tx_sh_r <= tx_sh_r << 1;
        end
        if (launch_trail) begin
          sdo_r   <= tx_sh_r[15];
          tx_sh_r <= tx_sh_r << 1;
        end
        if (capture) rx_sh_r <= {rx_sh_r[14:0], din_s_r}; // RQ9
        if (in_trail && half_tick) bits_r <= bits_r - smp_pkg::ONE5;
      end
    end
  end

  // remember length so phase 0 does not relaunch the first bit on the first leading edge
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) len_eff_r <= smp_pkg::LEN_MIN;
    else if (start_ok) len_eff_r <= len_eff;
  end

  // serial clock and selects
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      sclk_r  <= 1'b0;
      sel_n_r <= 2'h3;
    end else begin
      if (state_r == smp_pkg::ST_IDLE) sclk_r <= CFG.polarity; // RQ7
      else if ((in_lead || in_trail) && half_tick) sclk_r <= ~sclk_r; // RQ1
      if (start_ok && CFG.four_wire) // RQ3
        sel_n_r <= CFG.select_id ? 2'h1 : 2'h2; // RQ2
      else if (state_nxt == smp_pkg::ST_IDLE)
        sel_n_r <= 2'h3;
    end
  end
  assign SCLK  = sclk_r;
  assign SDO   = sdo_r; // RQ12
  assign SEL_N = sel_n_r;

  // completion pulse and transmit event; received bits are right aligned
  assign rx_push = in_trail && half_tick && last_bit; // RQ13
  // phase 0 takes its last bit at the final trailing edge itself, phase 1 has it already
  wire [15:0] rx_word = cfg_r.phase ? rx_sh_r : {rx_sh_r[14:0], din_s_r}; // RQ9
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      done_r  <= 1'b0;
      txreq_r <= 1'b0;
    end else begin
      done_r  <= rx_push;
      txreq_r <= start_ok; // RQ5
    end
  end
  assign RX_DMA_REQ = done_r; // RQ5
  assign TX_DMA_REQ = txreq_r;
  assign IRQ        = done_r; // RQ13

  // receive buffer stalls new transfers when full
  smp_buf2 u_rxbuf (
    .clk       (CORE_CLK),
    .nrst      (NRST),
    .in_valid  (rx_push),
    .in_ready  (rx_ready_in),
    .in_data   (rx_word),
    .out_valid (RX_VALID),
    .out_ready (RX_READY),
    .out_data  (RX_DATA)
  );
endmodule // serial_master_port

// ==== smp_pkg.sv ====
// shared constants and carriers for the serial master port
package smp_pkg;
  localparam int CHAR_W        = 16;
  localparam int LEN_W         = 5;
  localparam logic [4:0] LEN_MIN = 5'h02;
  localparam logic [4:0] LEN_MAX = 5'h10;
  localparam int DELAY_W       = 8;
  localparam int PRESCALE_W    = 8;
  localparam int NSEL          = 2;
  // least select-to-clock wait, in module clock periods
  localparam logic [7:0] SEL_SETUP_MIN  = 8'h02;
  // least clock-to-deselect wait, in module clock periods
  localparam logic [7:0] SEL_HOLD_MIN   = 8'h01;
  localparam logic [7:0] ONE8           = 8'h01;
  localparam logic [4:0] ONE5           = 5'h01;

  typedef struct packed {
    logic       polarity;
    logic       phase;
    logic       four_wire;
    logic       select_id;
    logic [4:0] char_len;
    logic [7:0] prescale;
    logic [7:0] select_to_clock_delay;
    logic [7:0] clock_to_deselect_delay;
  } cfg_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_LEAD  = 3'b010,
    ST_TRAIL = 3'b011,
    ST_HOLD  = 3'b100
  } state_e;
endpackage

// ==== smp_buf2.sv ====
`timescale 1ns/1ps
// two-entry valid/ready buffer for received characters
module smp_buf2 (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // fill side
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [15:0] in_data,
  // drain side
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [15:0]      out_data
);
  logic [15:0] mem_r [2];
  logic        wp_r;
  logic        rp_r;
  logic [1:0]  cnt_r;
  wire         push = in_valid && in_ready;
  wire         pop  = out_valid && out_ready;

  // flags from the occupancy count
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];

  // pointers and count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // storage
  always_ff @(posedge clk) begin
    if (push) mem_r[wp_r] <= in_data;
  end
endmodule // smp_buf2

// ==== serial_master_port_assertions.sv ====
// assertions on the serial master port pins
`timescale 1ns/1ps
module serial_master_port_assertions (
  // clock, reset, controls
  input wire logic CORE_CLK, NRST, TX_VALID, TX_READY, BUSY,
  input wire smp_pkg::cfg_s CFG,
  // events and pins
  input wire logic RX_VALID, IRQ, RX_DMA_REQ, TX_DMA_REQ, SCLK, SDO,
  input wire logic [1:0] SEL_N
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  logic sclk_q_r, seen_r;
  logic [8:0] per_r;
  wire rise = SCLK & ~sclk_q_r;
  // cycles since the last rising serial clock in a frame
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      {sclk_q_r, seen_r, per_r} <= 11'h000;
    end else begin
      sclk_q_r <= SCLK;
      seen_r <= (SEL_N != 2'h3) && (seen_r || rise);
      per_r <= rise ? 9'h001 : per_r + 9'h001;
    end
  end
  sequence quiet_two;
    $stable(SCLK) [*2];
  endsequence
  sequence tx_pulse;
    TX_DMA_REQ && BUSY && !TX_READY ##1 !TX_DMA_REQ;
  endsequence
  sel_choice_a: assert property (SEL_N != 2'h3 |-> SEL_N == (CFG.select_id ? 2'h1 : 2'h2))
    else $error("wrong select driven");
  three_wire_a: assert property (!CFG.four_wire |-> SEL_N == 2'h3)
    else $error("select driven in three-line mode");
  sel_setup_a: assert property ($fell(SEL_N[0]) || $fell(SEL_N[1]) |=> quiet_two)
    else $error("clock too soon after select");
  sel_hold_a: assert property ($rose(SEL_N[0]) || $rose(SEL_N[1]) |-> $stable(SCLK) && $past(SCLK, 2) == SCLK)
    else $error("select released too soon");
  tx_event_a: assert property (TX_VALID && TX_READY |=> tx_pulse)
    else $error("bad transmit event");
  rx_event_a: assert property (RX_DMA_REQ |-> IRQ ##[0:2] RX_VALID)
    else $error("bad receive event");
  sclk_period_a: assert property (rise && seen_r |-> per_r == {1'b0, CFG.prescale})
    else $error("wrong serial clock period");
  sdo_launch_a: assert property (!CFG.phase && SEL_N != 2'h3 && $stable(SEL_N) && $changed(SDO)
    |-> $changed(SCLK) && SCLK != CFG.polarity) else $error("data changed on wrong edge");
endmodule // serial_master_port_assertions

// ==== smp_slave_model.sv ====
// behavioural slave on the far side of the serial pins
`timescale 1ns/1ps
module smp_slave_model (
  // serial pins and mode
  input wire logic sclk, mosi, pol, pha,
  input wire logic [1:0] sel_n,
  // left-aligned word to send, bits seen
  input wire logic [15:0] pat,
  output logic miso,
  output logic [15:0] got
);
  logic [15:0] sr;
  initial miso = 1'b0;
  // load on select; the delayed phase sends its first bit at once
  always @(negedge (&sel_n)) begin
    sr = pat;
    got = 16'h0000;
    if (pha) begin
      miso = sr[15];
      sr = sr << 1;
    end
  end
  // launch on one clock edge, capture on the other
  always @(sclk) begin
    if (!(&sel_n) && ((sclk != pol) != pha)) begin
      miso = sr[15];
      sr = sr << 1;
    end else if (!(&sel_n)) begin
      got = {got[14:0], mosi};
    end
  end
  // a released line shows the opposite of its last value
  always @(posedge (&sel_n)) miso = ~miso;
endmodule // smp_slave_model

// ==== serial_master_port_tb.sv ====
// self-checking bench for the serial master port
`timescale 1ns/1ps
module serial_master_port_tb;
  typedef struct {logic [15:0] d; logic [15:0] m;} note_s;
  logic CORE_CLK, NRST, TX_VALID, TX_READY, RX_VALID, RX_READY, IRQ, RX_DMA_REQ, TX_DMA_REQ;
  logic BUSY, SCLK, SDO, SERIAL_DATA_IN, hold;
  logic [15:0] TX_DATA, RX_DATA, pat, got;
  logic [1:0] SEL_N;
  smp_pkg::cfg_s CFG;
  note_s q[$];
  note_s n;
  int mismatches, num_checks;
  serial_master_port uut (.*);
  smp_slave_model slave (.sclk(SCLK), .mosi(SDO), .pol(CFG.polarity), .pha(CFG.phase), .sel_n(SEL_N),
    .pat(pat), .miso(SERIAL_DATA_IN), .got(got));
  // module clock
  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  // receiver stalls at random, or fully while hold is set
  always @(posedge CORE_CLK) #1 RX_READY = !hold && ($urandom_range(0, 3) != 0);
  task automatic check(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // oldest note against each word taken from the buffer
  always @(posedge CORE_CLK) begin
    if (NRST && RX_VALID === 1'b1 && RX_READY === 1'b1) begin
      n = q.pop_front();
      check(RX_DATA & n.m, n.d);
    end
  end
  // one character: set the mode, request, wait for the end, check the far side
  task automatic xfer(input logic p, h, f, s, input logic [4:0] len, input logic [15:0] d, sd);
    logic [15:0] m;
    int k;
    m = 16'hFFFF >> (5'h10 - len);
    CFG = '{p, h, f, s, len, 8'h06 + 8'(2 * $urandom_range(0, 3)), 8'($urandom_range(1, 3)),
      8'($urandom_range(0, 3))};
    pat = sd << (5'h10 - len);
    // let the idle clock level settle before the request
    @(posedge CORE_CLK);
    #1 TX_DATA = d;
    TX_VALID = 1'b1;
    k = 0;
    while (TX_READY !== 1'b1 && k < 9000) begin
      @(posedge CORE_CLK);
      #1 k++;
    end
    @(posedge CORE_CLK);
    #1 TX_VALID = 1'b0;
    q.push_back('{sd & m & {16{f}}, m & {16{f}}});
    while (BUSY !== 1'b0 && k < 9000) begin
      @(posedge CORE_CLK);
      #1 k++;
    end
    if (k >= 9000) mismatches++;
    check({15'h0000, BUSY}, 16'h0000);
    if (f) check(got & m, d & m);
  endtask
  // cut a hang short
  initial begin
    #400000;
    mismatches++;
    end_sim();
  end
  initial begin
    void'($urandom(65));
    {NRST, TX_VALID, RX_READY, hold} = 4'h0;
    CFG = '0;
    TX_DATA = 16'h0000;
    pat = 16'h0000;
    mismatches = 0;
    num_checks = 0;
    repeat (8) @(posedge CORE_CLK);
    #1 NRST = 1'b1;
    @(posedge CORE_CLK);
    #1;
    // all four clock modes at the shortest, longest and a random length
    for (int i = 0; i < 12; i++) begin
      xfer(i[0], i[1], 1'b1, i[2], (i < 4) ? 5'h02 : (i < 8) ? 5'h10 : 5'(3 + $urandom_range(0, 12)),
        16'($urandom), 16'($urandom));
    end
    // three-line framing leaves both selects high
    xfer(1'b1, 1'b0, 1'b0, 1'b1, 5'h08, 16'h00A5, 16'h005A);
    for (int j = 0; j < 100 && q.size() != 0; j++) @(posedge CORE_CLK);
    // a stalled drain fills both entries and blocks a new request
    #1 hold = 1'b1;
    repeat (2) xfer(1'b0, 1'b1, 1'b1, 1'b0, 5'h0C, 16'($urandom), 16'($urandom));
    repeat (3) @(posedge CORE_CLK);
    #1 check({15'h0000, TX_READY}, 16'h0000);
    hold = 1'b0;
    for (int j = 0; j < 100 && q.size() != 0; j++) @(posedge CORE_CLK);
    check(16'(q.size()), 16'h0000);
    end_sim();
  end
endmodule // serial_master_port_tb
bind serial_master_port serial_master_port_assertions chk (.*);
